// >>> tps_pkg.sv
// tps_pkg: constants, field positions and state codes of the phase sequencer
// assumes one 100 MHz clock; times are kept in microseconds here
// What this block does
// - default mode is read-only, divider 119, register zero
// - low pin runs charge, rising edge starts read
// - read-only mode may follow a register write
// - write phase passes pin to antenna, fixed delay
// - low after write recharges, high again starts read
// - bit 0 is a low lead bit, not stored
// - divider codes pick factors 114 to 124
// - code 1111 takes the measured factor, where supported
// - bit 5 selects synchronous serial output
// - bit 6 selects fixed demodulator threshold
// - bit 7 announces a following test byte
// - sync mode leaves diagnosis 3 ms into charge
// - falling edge ends receive after 0.9 ms
// - pin still low then idle, diagnosis next clock
// - pin high stays idle, sleep after 100 ms
// - falling edge wakes from sleep, 2 ms delay
// - undefined state codes lead to idle
// - state timeouts count from state entry
// - read ends on low pin or 20 ms
// - diagnostic byte 2 ms into charge, af or ff
// - default divider is 119 of the clock
package tps_pkg;
    localparam int CLK_MHZ   = 100;
    localparam int DIAG_US   = 2000;
    localparam int SYNC_US   = 3000;
    localparam int STOP_US   = 900;
    localparam int SLEEP_US  = 100000;
    localparam int READ_US   = 20000;
    localparam int WAKE_US   = 2000;
    localparam int CELL_US   = 128;    // bit cell of register programming
    localparam int LOWCHG_US = 1000;   // low time in write phase that means charge
    localparam int BAUD_HZ   = 15625;
    localparam int WR_DLY    = 8;      // write-phase delay in clock cycles
    localparam int TMR_W     = 24;
    localparam int SYNC_BIT  = 5;
    localparam int THR_BIT   = 6;
    localparam int TEST_BIT  = 7;
    localparam logic [7:0] DIAG_OK     = 8'haf;
    localparam logic [7:0] DIAG_FAIL   = 8'hff;
    localparam logic [6:0] DIV_DEFAULT = 7'h77;
    localparam logic [7:0] DIV_BASE    = 8'h71;
    localparam logic [7:0] DIV_MAX     = 8'h7c;
    localparam logic [3:0] DIV_AUTO    = 4'hf;
    localparam logic [3:0] CODE_DEF    = 4'h0;
    localparam logic [3:0] LAST_BYTE   = 4'h7;
    localparam logic [3:0] LAST_TEST   = 4'hf;

    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_PROG   = 8'h02,
        ST_CHARGE = 8'h04,
        ST_WRITE  = 8'h08,
        ST_READ   = 8'h10,
        ST_STOP   = 8'h20,
        ST_SLEEP  = 8'h40,
        ST_WAKE   = 8'h80
    } tps_state_t;
endpackage : tps_pkg

// >>> tps_sci_tx.sv
// tps_sci_tx: byte sender towards the microcontroller, async or clocked
// assumes load only while not busy; sclk_i is a one-cycle pulse per clock
`timescale 1ns/1ns
module tps_sci_tx #(
    parameter int BAUD_CYC = 6400
) (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       sync_mode_i,
    input  wire logic       load_i,
    input  wire logic [7:0] data_i,
    input  wire logic       sclk_i,
    output logic            busy_o,
    output logic            sdo_o
);
    localparam logic [15:0] BAUD_END = 16'(BAUD_CYC - 1);

    typedef struct packed {
        logic        busy;
        logic        sdo;
        logic [3:0]  left;
        logic [15:0] baud;
        logic [8:0]  sh;
    } tps_tx_t;

    tps_tx_t q;
    tps_tx_t d;

    // async frame: start high, data lsb first, stop low; line idles low
    always_comb
    begin
        d = q;
        if (!q.busy)
        begin
            if (load_i)
            begin
                d.busy = 1'b1;
                d.sdo  = 1'b1;   // start bit, or byte-ready flag in sync mode
                d.baud = '0;
                if (sync_mode_i)
                begin
                    d.sh   = {1'b0, data_i};
                    d.left = 4'h8;
                end
                else
                begin
                    d.sh   = {1'b0, data_i};
                    d.left = 4'h9;
                end
            end
        end
        else if (sync_mode_i)
        begin
            // one bit per falling clock; last bit holds until the next byte
            if (sclk_i)
            begin
                d.sdo  = q.sh[0];
                d.sh   = q.sh >> 1;
                d.left = q.left - 4'h1;
                d.busy = (q.left != 4'h1);
            end
        end
        else
        begin
            d.baud = q.baud + 16'h0001;
            if (q.baud == BAUD_END)
            begin
                d.baud = '0;
                if (q.left == 4'h0)
                begin
                    d.busy = 1'b0;
                    d.sdo  = 1'b0;
                end
                else
                begin
                    d.sdo  = q.sh[0];
                    d.sh   = q.sh >> 1;
                    d.left = q.left - 4'h1;
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            q <= '0;
        else
            q <= d;
    end

    assign busy_o = q.busy;
    assign sdo_o  = q.sdo;
endmodule : tps_sci_tx

// >>> tps_sequencer.sv
// tps_sequencer: phase sequencer and mode register of the base station
// assumes demodulator, diagnosis and measurement results arrive on mclk_i
`timescale 1ns/1ns
module tps_sequencer #(
    parameter int T_DIAG   = tps_pkg::DIAG_US * tps_pkg::CLK_MHZ,
    parameter int T_SYNC   = tps_pkg::SYNC_US * tps_pkg::CLK_MHZ,
    parameter int T_STOP   = tps_pkg::STOP_US * tps_pkg::CLK_MHZ,
    parameter int T_SLEEP  = tps_pkg::SLEEP_US * tps_pkg::CLK_MHZ,
    parameter int T_READ   = tps_pkg::READ_US * tps_pkg::CLK_MHZ,
    parameter int T_WAKE   = tps_pkg::WAKE_US * tps_pkg::CLK_MHZ,
    parameter int T_CELL   = tps_pkg::CELL_US * tps_pkg::CLK_MHZ,
    parameter int T_LOWCHG = tps_pkg::LOWCHG_US * tps_pkg::CLK_MHZ,
    parameter int BAUD_CYC = tps_pkg::CLK_MHZ * 1000000 / tps_pkg::BAUD_HZ,
    parameter int WR_DLY   = tps_pkg::WR_DLY,
    parameter bit AUTO_DIV = 1'b1
) (
    input  wire logic       mclk_i,
    input  wire logic       arst_n_i,
    input  wire logic       tx_control_pin_i,
    input  wire logic       antenna_ok_i,
    input  wire logic       rx_valid_i,
    input  wire logic [7:0] rx_data_i,
    input  wire logic       meas_valid_i,
    input  wire logic [6:0] meas_count_i,
    output logic            serial_data_out_o,
    output logic            drive_en_o,
    output logic            carrier_on_o,
    output logic [6:0]      carrier_div_o,
    output logic            demod_en_o,
    output logic            sync_output_select_o,
    output logic            threshold_source_select_o,
    output logic [3:0]      divider_select_field_o,
    output logic            test_mode_flag_o,
    output logic [7:0]      state_o
);
    localparam int TW = tps_pkg::TMR_W;
    localparam logic [TW-1:0] C_DIAG   = TW'(T_DIAG - 1);
    localparam logic [TW-1:0] C_SYNC   = TW'(T_SYNC - 1);
    localparam logic [TW-1:0] C_STOP   = TW'(T_STOP - 1);
    localparam logic [TW-1:0] C_SLEEP  = TW'(T_SLEEP - 1);
    localparam logic [TW-1:0] C_READ   = TW'(T_READ - 1);
    localparam logic [TW-1:0] C_WAKE   = TW'(T_WAKE - 1);
    localparam logic [TW-1:0] C_CELL   = TW'(T_CELL - 1);
    localparam logic [TW-1:0] C_HALF   = TW'(T_CELL / 2 - 1);
    localparam logic [TW-1:0] C_LOWCHG = TW'(T_LOWCHG - 1);

    typedef struct packed {
        tps_pkg::tps_state_t st;
        logic [TW-1:0]       tmr;
        logic [TW-1:0]       low;
        logic                pin;
        logic [WR_DLY-1:0]   dly;
        logic [3:0]          pbit;
        logic [15:0]         psr;
        logic [7:0]          mode;
        logic [6:0]          div;
        logic                prog_done;
        logic                written;
        logic                diag_sent;
        logic                force_chg;
        logic                hold_v;
        logic [7:0]          hold;
        logic                drv;
        logic                car;
        logic                demod;
    } tps_seq_t;

    tps_seq_t            q;
    tps_seq_t            d;
    tps_pkg::tps_state_t nst;
    logic [1:0]          rst_sync;
    logic                rst_n;
    logic                pin_m;
    logic                pin;
    logic                fall;
    logic                rise;
    logic                tx_load;
    logic [7:0]          tx_data;
    logic                tx_busy;
    logic                sclk;
    logic                sync_mode;
    logic [3:0]          code;
    logic [7:0]          div_sum;

    // reset is asserted at once and released two clocks later
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // the pin comes from the microcontroller's domain; idle level is high
    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_m <= 1'b1;
            pin   <= 1'b1;
        end
        else
        begin
            pin_m <= tx_control_pin_i;
            pin   <= pin_m;
        end
    end

    assign fall      = q.pin & ~pin;
    assign rise      = ~q.pin & pin;
    assign sync_mode = q.mode[tps_pkg::SYNC_BIT];

    // next-state and datapath
    always_comb
    begin
        d       = q;
        nst     = q.st;
        tx_load = 1'b0;
        tx_data = q.hold;
        sclk    = 1'b0;
        code    = 4'h0;
        div_sum = 8'h00;
        d.pin   = pin;
        d.dly   = {q.dly[WR_DLY-2:0], pin};
        d.tmr   = q.tmr + 1'b1;
        case (q.st)
            tps_pkg::ST_IDLE:
            begin
                if (q.force_chg)
                begin
                    nst         = tps_pkg::ST_CHARGE;
                    d.force_chg = 1'b0;
                end
                else if (fall)
                    nst = tps_pkg::ST_PROG;
                else if (q.tmr == C_SLEEP)
                    nst = tps_pkg::ST_SLEEP;
            end
            tps_pkg::ST_PROG:
            begin
                // sample each cell at its middle, bit 0 first
                if (q.tmr == C_HALF)
                    d.psr[q.pbit] = pin;
                if (q.tmr == C_CELL)
                begin
                    d.tmr  = '0;
                    d.pbit = q.pbit + 4'h1;
                    if (q.pbit == (q.psr[tps_pkg::TEST_BIT] ? tps_pkg::LAST_TEST
                                                           : tps_pkg::LAST_BYTE))
                    begin
                        d.pbit = '0;
                        d.psr  = '0;
                        if (!pin)
                            nst = tps_pkg::ST_CHARGE;
                        else
                        begin
                            nst = tps_pkg::ST_IDLE;
                            // a high lead bit marks a broken frame; drop it
                            if (!q.psr[0])
                            begin
                                d.mode      = {q.psr[7:1], 1'b0};
                                d.prog_done = 1'b1;
                                if (!AUTO_DIV && q.psr[4:1] == tps_pkg::DIV_AUTO)
                                    d.mode[4:1] = q.mode[4:1];
                            end
                        end
                    end
                end
            end
            tps_pkg::ST_CHARGE:
            begin
                if (q.tmr == C_DIAG && !q.diag_sent)
                begin
                    tx_load     = 1'b1;
                    tx_data     = antenna_ok_i ? tps_pkg::DIAG_OK : tps_pkg::DIAG_FAIL;
                    d.diag_sent = 1'b1;
                end
                sclk = sync_mode & fall & tx_busy;
                // sync mode ignores a rising pin; it leaves at C_SYNC once the byte is clocked out
                if (sync_mode ? (q.tmr >= C_SYNC && q.diag_sent && !tx_busy) : rise)
                begin
                    d.diag_sent = 1'b0;
                    if (q.prog_done && !q.written)
                        nst = tps_pkg::ST_WRITE;
                    else
                        nst = tps_pkg::ST_READ;
                end
            end
            tps_pkg::ST_WRITE:
            begin
                d.low = pin ? '0 : q.low + 1'b1;
                // a long low is a new charge, short lows are write data
                if (q.low == C_LOWCHG)
                begin
                    nst       = tps_pkg::ST_CHARGE;
                    d.written = 1'b1;
                    d.low     = '0;
                end
            end
            tps_pkg::ST_READ:
            begin
                if (q.hold_v && !tx_busy)
                begin
                    tx_load  = 1'b1;
                    d.hold_v = 1'b0;
                end
                sclk = sync_mode & fall & tx_busy;
                if (q.tmr == C_READ || (fall && !(sync_mode && tx_busy)))
                begin
                    d.prog_done = 1'b0;
                    d.written   = 1'b0;
                    d.hold_v    = 1'b0;
                    nst = (q.tmr == C_READ) ? tps_pkg::ST_IDLE : tps_pkg::ST_STOP;
                end
            end
            tps_pkg::ST_STOP:
            begin
                if (q.tmr == C_STOP)
                begin
                    nst         = tps_pkg::ST_IDLE;
                    d.force_chg = !pin;
                end
            end
            tps_pkg::ST_SLEEP:
            begin
                if (fall)
                    nst = tps_pkg::ST_WAKE;
            end
            tps_pkg::ST_WAKE:
            begin
                if (q.tmr == C_WAKE)
                begin
                    nst         = tps_pkg::ST_IDLE;
                    d.force_chg = !pin;
                end
            end
            default:
                nst = tps_pkg::ST_IDLE;
        endcase
        // received bytes go out inverted; a new byte wins over the drain
        if (rx_valid_i && q.st == tps_pkg::ST_READ && nst == tps_pkg::ST_READ)
        begin
            d.hold_v = 1'b1;
            d.hold   = ~rx_data_i;
        end
        if (nst != q.st)
            d.tmr = '0;
        d.st = nst;
        // carrier divider follows the stored code
        code    = d.mode[4:1];
        div_sum = tps_pkg::DIV_BASE + {4'h0, code};
        if (AUTO_DIV && code == tps_pkg::DIV_AUTO)
        begin
            if (meas_valid_i)
                d.div = meas_count_i;
        end
        else if (code == tps_pkg::CODE_DEF)
            d.div = tps_pkg::DIV_DEFAULT;
        else if (div_sum > tps_pkg::DIV_MAX)
            d.div = tps_pkg::DIV_MAX[6:0];
        else
            d.div = div_sum[6:0];
        d.drv   = (nst == tps_pkg::ST_CHARGE) || (nst == tps_pkg::ST_WRITE);
        d.car   = (nst == tps_pkg::ST_CHARGE) || (nst == tps_pkg::ST_WRITE && q.dly[WR_DLY-1]);
        d.demod = (nst == tps_pkg::ST_READ) || (nst == tps_pkg::ST_WRITE);
    end

    // mode register and other fields reset to zero; state resets to idle, pin high, divider to default
    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q     <= '0;
            q.st  <= tps_pkg::ST_IDLE;
            q.pin <= 1'b1;
            q.div <= tps_pkg::DIV_DEFAULT;
        end
        else
            q <= d;
    end

    tps_sci_tx #(
        .BAUD_CYC (BAUD_CYC)
    ) u_tx (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n),
        .sync_mode_i (sync_mode),
        .load_i      (tx_load),
        .data_i      (tx_data),
        .sclk_i      (sclk),
        .busy_o      (tx_busy),
        .sdo_o       (serial_data_out_o)
    );

    assign drive_en_o                = q.drv;
    assign carrier_on_o              = q.car;
    assign carrier_div_o             = q.div;
    assign demod_en_o                = q.demod;
    assign sync_output_select_o      = q.mode[tps_pkg::SYNC_BIT];
    assign threshold_source_select_o = q.mode[tps_pkg::THR_BIT];
    assign divider_select_field_o    = q.mode[4:1];
    assign test_mode_flag_o          = q.mode[tps_pkg::TEST_BIT];
    assign state_o                   = q.st;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n);

    // checks on the sequencer
    chk_default_div: assert property (
        q.mode[4:1] == tps_pkg::CODE_DEF |-> carrier_div_o == tps_pkg::DIV_DEFAULT)
        else $error("divider not default for code zero");
    chk_rise_read: assert property (
        q.st == tps_pkg::ST_CHARGE && !sync_mode && rise && !q.prog_done
        |=> q.st == tps_pkg::ST_READ && !drive_en_o)
        else $error("rising edge did not start read");
    chk_write_mod: assert property (
        q.st == tps_pkg::ST_WRITE && $past(q.st) == tps_pkg::ST_WRITE
        |-> carrier_on_o == $past(pin, WR_DLY + 1))
        else $error("write carrier not delayed pin");
    chk_lead_bit: assert property (
        q.st == tps_pkg::ST_PROG && nst == tps_pkg::ST_IDLE && q.psr[0]
        |=> $stable(q.mode) && !q.mode[0])
        else $error("frame with high lead bit stored");
    chk_fail_safe: assert property (
        !$onehot(q.st) |=> q.st == tps_pkg::ST_IDLE)
        else $error("illegal state did not go idle");
    chk_stop_bound: assert property (
        q.st == tps_pkg::ST_STOP && q.tmr == C_STOP |=> q.st == tps_pkg::ST_IDLE)
        else $error("stop delay overran");
    chk_low_rechg: assert property (
        q.st == tps_pkg::ST_STOP && q.tmr == C_STOP && !pin
        |=> q.st == tps_pkg::ST_IDLE ##1 q.st == tps_pkg::ST_CHARGE)
        else $error("idle to diagnosis not one clock");
    chk_sleep_entry: assert property (
        $rose(q.st == tps_pkg::ST_SLEEP)
        |-> $past(q.st) == tps_pkg::ST_IDLE && $past(q.tmr) == C_SLEEP)
        else $error("sleep entered at wrong time");
    chk_read_limit: assert property (
        q.st == tps_pkg::ST_READ |-> q.tmr <= C_READ)
        else $error("read phase overran");
    chk_diag_send: assert property (
        q.st == tps_pkg::ST_CHARGE && q.tmr == C_DIAG && !q.diag_sent
        |=> u_tx.busy_o && serial_data_out_o)
        else $error("diagnostic byte not started");
    chk_sync_exit: assert property (
        sync_mode && $past(q.st) == tps_pkg::ST_CHARGE && q.st != tps_pkg::ST_CHARGE
        |-> $past(q.tmr) >= C_SYNC && !$past(tx_busy))
        else $error("sync diagnosis left early");
endmodule : tps_sequencer

// >>> tps_mcu_model.sv
// tps_mcu_model: microcontroller on the control pin and the serial output
// assumes the bench calls its tasks; the pin idles high between uses
`timescale 1ns/1ns
module tps_mcu_model #(
    parameter int T_CELL   = 40,
    parameter int BAUD_CYC = 16
) (
    input  wire logic mclk_i,
    input  wire logic sdo_i,
    output logic      pin_o
);
    initial pin_o = 1'b1;

    // drive one level from the next edge for a number of cycles
    task automatic hold(input logic lvl, input int cyc);
        @(posedge mclk_i);
        pin_o <= lvl;
        repeat (cyc - 1) @(posedge mclk_i);
    endtask : hold

    // a short fall opens the frame, so a high bit 0 can still be sent
    task automatic send_frame(input logic [7:0] b);
        hold(1'b0, 5);
        hold(b[0], T_CELL - 5);
        for (int i = 1; i < 7; i++)
            hold(b[i], T_CELL);
        hold(b[7], T_CELL * 3 / 4);
        hold(1'b1, T_CELL / 4 + 8);
    endtask : send_frame

    // start bit high, then eight bits lsb first sampled mid-bit
    task automatic get_byte(output logic [7:0] b);
        int n;
        n = 0;
        b = 8'hxx;
        while (sdo_i !== 1'b1 && n < 4000)
        begin
            @(posedge mclk_i);
            n++;
        end
        if (sdo_i === 1'b1)
        begin
            repeat (BAUD_CYC / 2) @(posedge mclk_i);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BAUD_CYC) @(posedge mclk_i);
                b[i] = sdo_i;
            end
        end
    endtask : get_byte
endmodule : tps_mcu_model

// >>> test_transponder_phase_sequencer.sv
// test_transponder_phase_sequencer: directed bench of the phase sequencer
// assumes shortened phase times; the mcu model owns the control pin
`timescale 1ns/1ns
module test_transponder_phase_sequencer;
    localparam int TC = 40;
    localparam int TS = 200;
    localparam int TR = 3000;
    localparam int TL = 500;
    localparam int TP = 2000;
    localparam int TW = 300;
    localparam int TD = 400;
    localparam int TY = 600;
    localparam int TB = 16;
    logic       mclk_i;
    logic       arst_n_i;
    logic       pin;
    logic       ant_ok;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       meas_valid;
    logic [6:0] meas_count;
    logic       sdo;
    logic       drive_en;
    logic       carrier_on;
    logic       demod;
    logic [6:0] div;
    logic       sync_o;
    logic       thr_o;
    logic [3:0] field_o;
    logic       test_o;
    logic [7:0] state_o;
    logic [7:0] rx_b;
    int         mismatches;
    int         checked;

    tps_sequencer #(.T_DIAG(TD), .T_SYNC(TY), .T_STOP(TS), .T_SLEEP(TP),
        .T_READ(TR), .T_WAKE(TW), .T_CELL(TC), .T_LOWCHG(TL), .BAUD_CYC(TB)
    ) u_tps_sequencer (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .tx_control_pin_i(pin),
        .antenna_ok_i(ant_ok), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
        .meas_valid_i(meas_valid), .meas_count_i(meas_count),
        .serial_data_out_o(sdo), .drive_en_o(drive_en), .carrier_on_o(carrier_on),
        .carrier_div_o(div), .demod_en_o(demod), .sync_output_select_o(sync_o),
        .threshold_source_select_o(thr_o), .divider_select_field_o(field_o),
        .test_mode_flag_o(test_o), .state_o(state_o)
    );

    tps_mcu_model #(.T_CELL(TC), .BAUD_CYC(TB)) u_tps_mcu_model (
        .mclk_i(mclk_i), .sdo_i(sdo), .pin_o(pin)
    );

    task automatic give_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    // bounded wait for a state; a miss ends the run
    task automatic wait_state(input logic [7:0] exp, input int bound);
        int n;
        n = 0;
        while (state_o !== exp && n < bound)
        begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        check(state_o, exp);
        if (state_o !== exp)
            give_verdict();
    endtask : wait_state

    task automatic diag_read();
        u_tps_mcu_model.hold(1'b0, 1);
        // a fall in idle first runs eight register cells; low at the end means charge
        wait_state(tps_pkg::ST_CHARGE, 8 * TC + 20);
        check({7'h00, drive_en}, 8'h01);
        u_tps_mcu_model.get_byte(rx_b);
        check(rx_b, 8'haf);
        u_tps_mcu_model.hold(1'b1, 1);
        wait_state(tps_pkg::ST_READ, 10);
        ant_ok <= 1'b0;
        u_tps_mcu_model.hold(1'b0, 1);
        wait_state(tps_pkg::ST_STOP, 10);
        repeat (TS - 20) @(posedge mclk_i);
        check(state_o, tps_pkg::ST_STOP);
        wait_state(tps_pkg::ST_CHARGE, 40);
        u_tps_mcu_model.get_byte(rx_b);
        check(rx_b, 8'hff);
        u_tps_mcu_model.hold(1'b1, 1);
        wait_state(tps_pkg::ST_READ, 10);
        check({7'h00, demod}, 8'h01);
        // a received byte goes out inverted once the sender is idle
        repeat (40) @(posedge mclk_i);
        rx_valid <= 1'b1;
        rx_data <= 8'h5a;
        @(posedge mclk_i);
        rx_valid <= 1'b0;
        u_tps_mcu_model.get_byte(rx_b);
        check(rx_b, 8'ha5);
        repeat (TR - 230) @(posedge mclk_i);
        check(state_o, tps_pkg::ST_READ);
        wait_state(tps_pkg::ST_IDLE, 80);
    endtask : diag_read

    // bit 7 stays low in every frame, the test byte is never announced
    task automatic program_codes();
        logic [7:0] frm [6] = '{8'h62, 8'h00, 8'h04, 8'h0c, 8'h02, 8'h16};
        logic [7:0] fac [6] = '{8'h72, 8'h77, 8'h73, 8'h77, 8'h72, 8'h7c};
        for (int i = 0; i < 6; i++)
        begin
            u_tps_mcu_model.send_frame(frm[i]);
            wait_state(tps_pkg::ST_IDLE, 40);
            check({4'h0, field_o}, {4'h0, frm[i][4:1]});
            check({1'b0, div}, fac[i]);
            check({6'h00, thr_o, sync_o}, {6'h00, frm[i][6:5]});
        end
        u_tps_mcu_model.send_frame(8'h17);
        wait_state(tps_pkg::ST_IDLE, 40);
        check({4'h0, field_o}, 8'h0b);
        u_tps_mcu_model.send_frame(8'h1e);
        wait_state(tps_pkg::ST_IDLE, 40);
        @(posedge mclk_i);
        meas_valid <= 1'b1;
        meas_count <= 7'h78;
        @(posedge mclk_i);
        meas_valid <= 1'b0;
        repeat (3) @(posedge mclk_i);
        check({1'b0, div}, 8'h78);
    endtask : program_codes

    task automatic write_phase();
        u_tps_mcu_model.hold(1'b0, 100);
        wait_state(tps_pkg::ST_CHARGE, 8 * TC + 20);
        u_tps_mcu_model.hold(1'b1, 20);
        wait_state(tps_pkg::ST_WRITE, 10);
        u_tps_mcu_model.hold(1'b0, 20);
        check({7'h00, carrier_on}, 8'h00);
        u_tps_mcu_model.hold(1'b1, 20);
        check({7'h00, carrier_on}, 8'h01);
        u_tps_mcu_model.hold(1'b0, TL + 20);
        wait_state(tps_pkg::ST_CHARGE, 10);
        u_tps_mcu_model.hold(1'b1, 1);
        wait_state(tps_pkg::ST_READ, 10);
        u_tps_mcu_model.hold(1'b0, 20);
        wait_state(tps_pkg::ST_STOP, 10);
        u_tps_mcu_model.hold(1'b1, 1);
        wait_state(tps_pkg::ST_IDLE, TS + 20);
    endtask : write_phase

    task automatic sleep_wake();
        repeat (TP - 100) @(posedge mclk_i);
        check(state_o, tps_pkg::ST_IDLE);
        wait_state(tps_pkg::ST_SLEEP, 200);
        u_tps_mcu_model.hold(1'b0, 5);
        u_tps_mcu_model.hold(1'b1, 1);
        wait_state(tps_pkg::ST_WAKE, 10);
        wait_state(tps_pkg::ST_IDLE, TW + 20);
    endtask : sleep_wake

    // clocked output: each fall of the pin shifts one diagnosis bit out
    task automatic sync_diag();
        int n;
        n = 0;
        ant_ok <= 1'b1;
        u_tps_mcu_model.send_frame(8'h20);
        wait_state(tps_pkg::ST_IDLE, 40);
        check({7'h00, sync_o}, 8'h01);
        u_tps_mcu_model.hold(1'b0, 1);
        wait_state(tps_pkg::ST_CHARGE, 8 * TC + 20);
        while (sdo !== 1'b1 && n < 500)
        begin
            @(posedge mclk_i);
            n++;
        end
        for (int i = 0; i < 8; i++)
        begin
            u_tps_mcu_model.hold(1'b1, 4);
            u_tps_mcu_model.hold(1'b0, 8);
            rx_b[i] = sdo;
        end
        u_tps_mcu_model.hold(1'b1, 1);
        check(rx_b, 8'haf);
        // byte is out but the phase must last until its fixed end
        check(state_o, tps_pkg::ST_CHARGE);
        wait_state(tps_pkg::ST_WRITE, 200);
    endtask : sync_diag

    initial
    begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // reset values are read while reset is still held
    initial
    begin
        mismatches = 0;
        checked = 0;
        arst_n_i = 1'b0;
        ant_ok = 1'b1;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        meas_valid = 1'b0;
        meas_count = 7'h00;
        repeat (5) @(posedge mclk_i);
        check(state_o, tps_pkg::ST_IDLE);
        check({1'b0, div}, 8'h77);
        check({field_o, sync_o, thr_o, test_o, drive_en}, 8'h00);
        arst_n_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        diag_read();
        program_codes();
        write_phase();
        sleep_wake();
        sync_diag();
        give_verdict();
    end
endmodule : test_transponder_phase_sequencer
